// ===== shared/fcc_regs.vh
// Register offsets, field positions, reset values and counts for the capture/compare timer.
// Notes on behaviour
// RULE1 - Each capture channel takes rising edges when its edge pick is 1, falling when 0.
// RULE2 - A capture meeting an upper-byte read of its register is delayed one clock.
// RULE3 - Buffered channel A with opposite A/C edge picks captures both edges of pin A.
// RULE4 - Buffered: edge matching the buffer pick sets its flag, never loads its register.
// RULE5 - Buffered: upper-byte read of either pair register delays the capture one clock.
// RULE6 - The capture flag sets on the same edge the counter value is loaded.
// RULE7 - Compare match fires only as the counter leaves the matching value.
// RULE8 - Wrap flag sets when the counter rolls from FFFF to 0000.
// RULE9 - All timer registers are held at reset values during low-power modes.
// RULE10 - Seven enable-gated sources share one request, flags tell them apart.
// RULE11 - Each status flag is set by its own capture, match or wrap event.
// RULE12 - A counter clear on a low-byte counter write wins; the write is dropped.
// RULE13 - An increment on a low-byte counter write is skipped; the write wins.
// RULE14 - A match on a low-byte compare write is suppressed; the write completes.
// RULE15 - Internal increments come from falling edges of the selected divided clock.
// RULE16 - Switching between internal and external source may add one increment.
// RULE17 - After reset the counter starts at 0000 and counts up continuously.
// RULE18 - Clock pick 00, 01, 10 give clk/2, clk/8, clk/32; 11 external rising edge.
// RULE19 - Buffered capture moves the old main value into the buffer register.
// RULE20 - Upper byte read returns directly and latches the low byte for the next read; compare reads return both bytes directly, with no latch.
// RULE21 - The shared request is high while any enabled flag is set.
// RULE22 - A flag clears only by writing 0 after having read it as 1.
`ifndef FCC_REGS_VH
`define FCC_REGS_VH

// ==========================================================================
// Byte offsets on the register bus.
`define FCC_ADR_IRQ_ENABLE 5'h00
`define FCC_ADR_STATUS 5'h01
`define FCC_ADR_COUNT_HI 5'h02
`define FCC_ADR_COUNT_LO 5'h03
`define FCC_ADR_COMPARE_HI 5'h04
`define FCC_ADR_COMPARE_LO 5'h05
`define FCC_ADR_CONTROL 5'h06
`define FCC_ADR_OUT_CTRL 5'h07
`define FCC_ADR_CAPTURE_BASE 2'h1
`define FCC_ADR_UNMAPPED_DATA 8'h00

// ==========================================================================
// Field positions.
`define FCC_CTRL_EDGE_A 7
`define FCC_CTRL_BUF_A 3
`define FCC_CTRL_BUF_B 2
`define FCC_OUT_SEL_B 4
`define FCC_OUT_EN_A 3
`define FCC_OUT_EN_B 2
`define FCC_OUT_LVL_A 1
`define FCC_OUT_LVL_B 0

// ==========================================================================
// Reset values and counts.
`define FCC_RST_COUNT 16'h0000
`define FCC_COUNT_TOP 16'hFFFF
`define FCC_RST_COMPARE 16'hFFFF
`define FCC_RST_BYTE 8'h00
`define FCC_OUT_CTRL_FILL 3'h7
`define FCC_PICK_DIV2 2'h0
`define FCC_PICK_DIV8 2'h1
`define FCC_PICK_DIV32 2'h2

`endif

// ===== rtl/fcc_edge.v
// Edge detector for one capture pin.
module fcc_edge (
	input wire sys_clk,
	input wire nrst,
	input wire hold,
	input wire pin,
	output wire rise,
	output wire fall
);
	reg last;

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			last <= 1'b0;
		end else if (hold) begin
			last <= 1'b0;
		end else begin
			last <= pin;
		end
	end

	assign rise = pin & ~last & ~hold;
	assign fall = ~pin & last & ~hold;
endmodule

// ===== rtl/fcc_prescale.v
// Counter clock source: system clock divider and external clock pick.
`include "fcc_regs.vh"
module fcc_prescale (
	input wire sys_clk,
	input wire nrst,
	input wire hold,
	input wire [1:0] clk_pick,
	input wire ext_clk_pin,
	output wire tick
);
	reg [4:0] div;
	reg last;
	reg level;

	// The external pin is inverted so that its rising edge, like the
	// divided clocks, shows as a falling edge of one common level.
	always @* begin
		case (clk_pick)
			`FCC_PICK_DIV2: level = div[0]; // [RULE18]
			`FCC_PICK_DIV8: level = div[2];
			`FCC_PICK_DIV32: level = div[4];
			default: level = ~ext_clk_pin;
		endcase
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div <= 5'h00;
			last <= 1'b0;
		end else if (hold) begin
			div <= 5'h00;
			last <= 1'b0;
		end else begin
			div <= div + 5'h01;
			last <= level;
		end
	end

	// A pick change from a high level to a low one is a falling edge too,
	// and a change to or from the external pin may add one count.
	assign tick = last & ~level & ~hold; // [RULE15] [RULE16]
endmodule

// ===== rtl/fcc_timer.v
// Free-running capture/compare timer with an Avalon-MM byte register slave.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`include "fcc_regs.vh"
module fcc_timer (
	input wire sys_clk,
	input wire nrst,
	input wire low_power_mode,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [7:0] avs_writedata,
	output reg [7:0] avs_readdata,
	output reg avs_waitrequest,
	input wire capture_pin_a,
	input wire capture_pin_b,
	input wire capture_pin_c,
	input wire capture_pin_d,
	input wire ext_clk_pin,
	output reg compare_pin_a,
	output reg compare_pin_b,
	output reg irq
);
	// ==========================================================================
	// Storage.
	reg [15:0] free_run_counter;
	reg [15:0] compare_value_a;
	reg [15:0] compare_value_b;
	reg [15:0] capture_value [0:3];
	reg [7:0] temp_byte;
	reg [6:0] irq_enable_reg;
	reg [7:0] timer_control_reg;
	reg [4:0] compare_output_ctrl_reg;
	reg clear_on_match_a;
	reg [6:0] status_flags;
	reg [6:0] flags_seen;
	reg [3:0] capture_pend;
	reg match_out_a;
	reg match_out_b;

	reg [7:0] next_readdata;
	reg [3:0] capture_raw;
	reg [3:0] capture_fire;
	reg [3:0] next_capture_pend;
	reg [3:0] read_hi_cap;
	reg pair_buf;
	reg pick_own;
	reg pick_mate;
	integer i;
	integer mate;
	integer j;

	wire [3:0] pin_vec;
	wire [3:0] pin_rise;
	wire [3:0] pin_fall;
	wire tick;

	// ==========================================================================
	// Bus handshake.
	// Every access gets one wait cycle: read data is latched at the edge
	// that drops waitrequest, and writes land at the edge that sees it low.
	wire bus_req = avs_read | avs_write;
	wire bus_take = bus_req & ~avs_waitrequest;
	wire wr_ce = bus_take & avs_write;
	wire rd_ce = bus_req & avs_waitrequest & avs_read;
	wire cap_region = (avs_address[4:3] == `FCC_ADR_CAPTURE_BASE);
	wire [1:0] cap_index = avs_address[2:1];
	wire sel_b = compare_output_ctrl_reg[`FCC_OUT_SEL_B];

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= `FCC_RST_BYTE;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (rd_ce) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	always @* begin
		next_readdata = `FCC_ADR_UNMAPPED_DATA;
		if (cap_region) begin
			if (avs_address[0]) begin
				next_readdata = temp_byte;
			end else begin
				next_readdata = capture_value[cap_index][15:8];
			end
		end else begin
			case (avs_address)
				`FCC_ADR_IRQ_ENABLE: next_readdata = {irq_enable_reg, 1'b0};
				`FCC_ADR_STATUS: next_readdata = {status_flags, clear_on_match_a};
				`FCC_ADR_COUNT_HI: next_readdata = free_run_counter[15:8]; // [RULE20]
				`FCC_ADR_COUNT_LO: next_readdata = temp_byte;
				`FCC_ADR_COMPARE_HI: begin
					next_readdata = sel_b ? compare_value_b[15:8] : compare_value_a[15:8];
				end
				`FCC_ADR_COMPARE_LO: begin
					next_readdata = sel_b ? compare_value_b[7:0] : compare_value_a[7:0];
				end
				`FCC_ADR_CONTROL: next_readdata = timer_control_reg;
				`FCC_ADR_OUT_CTRL: begin
					next_readdata = {`FCC_OUT_CTRL_FILL, compare_output_ctrl_reg};
				end
				default: next_readdata = `FCC_ADR_UNMAPPED_DATA;
			endcase
		end
	end

	// ==========================================================================
	// Clock source and capture pins.
	assign pin_vec = {capture_pin_d, capture_pin_c, capture_pin_b, capture_pin_a};

	fcc_prescale u_prescale (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.hold(low_power_mode),
		.clk_pick(timer_control_reg[1:0]),
		.ext_clk_pin(ext_clk_pin),
		.tick(tick)
	);

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : pins
			fcc_edge u_edge (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.hold(low_power_mode),
				.pin(pin_vec[g]),
				.rise(pin_rise[g]),
				.fall(pin_fall[g])
			);
		end
	endgenerate

	// ==========================================================================
	// Capture events.
	// Channels 0..3 are a..d; channel c buffers a and d buffers b.
	// A capture held back by an upper-byte read waits one clock in capture_pend,
	// so the low byte latched by that read still belongs to the same value.
	always @* begin
		capture_raw = 4'h0;
		capture_fire = 4'h0;
		next_capture_pend = 4'h0;
		read_hi_cap = 4'h0;
		pair_buf = 1'b0;
		pick_own = 1'b0;
		pick_mate = 1'b0;
		mate = 0;
		for (i = 0; i < 4; i = i + 1) begin
			read_hi_cap[i] = rd_ce & cap_region & ~avs_address[0] & (cap_index == i);
		end
		for (i = 0; i < 4; i = i + 1) begin
			mate = (i < 2) ? i + 2 : i - 2;
			pair_buf = (i % 2 == 0) ? timer_control_reg[`FCC_CTRL_BUF_A] :
				timer_control_reg[`FCC_CTRL_BUF_B];
			pick_own = timer_control_reg[`FCC_CTRL_EDGE_A - i];
			pick_mate = timer_control_reg[`FCC_CTRL_EDGE_A - mate];
			if (i < 2) begin
				// Buffered main channel also takes the buffer's pick on its pin.
				capture_raw[i] = (pick_own ? pin_rise[i] : pin_fall[i]) | // [RULE1]
					(pair_buf & (pick_mate ? pin_rise[i] : pin_fall[i])); // [RULE3]
			end else if (pair_buf) begin
				capture_raw[i] = pick_own ? pin_rise[mate] : pin_fall[mate]; // [RULE4]
			end else begin
				capture_raw[i] = pick_own ? pin_rise[i] : pin_fall[i]; // [RULE1]
			end
			if (read_hi_cap[i] | (pair_buf & read_hi_cap[mate])) begin
				next_capture_pend[i] = capture_raw[i]; // [RULE2] [RULE5]
			end else begin
				capture_fire[i] = capture_raw[i];
			end
			capture_fire[i] = capture_fire[i] | capture_pend[i];
		end
	end

	// ==========================================================================
	// Counter, compare match and contention.
	// A compare write in the same cycle as a match wins and the match is lost,
	// so software that moves a compare value may skip one output event.
	wire wr_count_lo = wr_ce & (avs_address == `FCC_ADR_COUNT_LO);
	wire wr_compare_lo = wr_ce & (avs_address == `FCC_ADR_COMPARE_LO);
	// Match is taken on the tick that moves the counter off the value.
	wire match_a = tick & (free_run_counter == compare_value_a) & // [RULE7]
		~(wr_compare_lo & ~sel_b); // [RULE14]
	wire match_b = tick & (free_run_counter == compare_value_b) &
		~(wr_compare_lo & sel_b); // [RULE14]
	wire count_clear = match_a & clear_on_match_a;
	wire wrap = tick & (free_run_counter == `FCC_COUNT_TOP) & ~count_clear &
		~wr_count_lo; // [RULE8]
	wire [6:0] flag_set = {capture_fire[0], capture_fire[1], capture_fire[2],
		capture_fire[3], match_a, match_b, wrap}; // [RULE11]
	wire [6:0] flag_clr = (wr_ce & (avs_address == `FCC_ADR_STATUS)) ?
		(flags_seen & ~avs_writedata[7:1]) : 7'h00; // [RULE22]

	// Order of the branches sets the contention outcome: a match clear beats
	// a low-byte write, and that write beats a tick, which is then dropped.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			free_run_counter <= `FCC_RST_COUNT;
		end else if (low_power_mode) begin
			free_run_counter <= `FCC_RST_COUNT; // [RULE9]
		end else if (count_clear) begin
			free_run_counter <= `FCC_RST_COUNT; // [RULE12]
		end else if (wr_count_lo) begin
			free_run_counter <= {temp_byte, avs_writedata}; // [RULE13]
		end else if (tick) begin
			free_run_counter <= free_run_counter + 16'h0001; // [RULE17]
		end
	end

	// ==========================================================================
	// Capture registers and the shared byte latch.
	// The buffer takes the old main value in the same edge as the new capture,
	// and the clocked loops use their own index apart from the decode above.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (j = 0; j < 4; j = j + 1) begin
				capture_value[j] <= `FCC_RST_COUNT;
			end
			capture_pend <= 4'h0;
		end else if (low_power_mode) begin
			for (j = 0; j < 4; j = j + 1) begin
				capture_value[j] <= `FCC_RST_COUNT; // [RULE9]
			end
			capture_pend <= 4'h0;
		end else begin
			capture_pend <= next_capture_pend;
			for (j = 0; j < 2; j = j + 1) begin
				if (capture_fire[j]) begin
					capture_value[j] <= free_run_counter; // [RULE6]
					if (timer_control_reg[`FCC_CTRL_BUF_A - j]) begin
						capture_value[j + 2] <= capture_value[j]; // [RULE19]
					end
				end
			end
			for (j = 2; j < 4; j = j + 1) begin
				if (capture_fire[j] & ~timer_control_reg[`FCC_CTRL_BUF_A + 2 - j]) begin
					capture_value[j] <= free_run_counter; // [RULE6]
				end
			end
		end
	end

	// The latch is shared by all wide registers, so an interleaved access
	// to another wide register between the two bytes corrupts the pair.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			temp_byte <= `FCC_RST_BYTE;
		end else if (low_power_mode) begin
			temp_byte <= `FCC_RST_BYTE;
		end else if (rd_ce & cap_region & ~avs_address[0]) begin
			temp_byte <= capture_value[cap_index][7:0]; // [RULE20]
		end else if (rd_ce & (avs_address == `FCC_ADR_COUNT_HI)) begin
			temp_byte <= free_run_counter[7:0]; // [RULE20]
		end else if (wr_ce & ((avs_address == `FCC_ADR_COUNT_HI) |
			(avs_address == `FCC_ADR_COMPARE_HI))) begin
			temp_byte <= avs_writedata;
		end
	end

	// ==========================================================================
	// Control registers and flags.
	// Low power acts as a synchronous reset of every register while the bus
	// still answers, so software reads the reset values during the hold.
	// A flag clears only for bits read as 1 since the last clear.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			compare_value_a <= `FCC_RST_COMPARE;
			compare_value_b <= `FCC_RST_COMPARE;
			irq_enable_reg <= 7'h00;
			timer_control_reg <= `FCC_RST_BYTE;
			compare_output_ctrl_reg <= 5'h00;
			clear_on_match_a <= 1'b0;
			status_flags <= 7'h00;
			flags_seen <= 7'h00;
		end else if (low_power_mode) begin
			compare_value_a <= `FCC_RST_COMPARE; // [RULE9]
			compare_value_b <= `FCC_RST_COMPARE;
			irq_enable_reg <= 7'h00;
			timer_control_reg <= `FCC_RST_BYTE;
			compare_output_ctrl_reg <= 5'h00;
			clear_on_match_a <= 1'b0;
			status_flags <= 7'h00;
			flags_seen <= 7'h00;
		end else begin
			if (wr_compare_lo & ~sel_b) begin
				compare_value_a <= {temp_byte, avs_writedata}; // [RULE14]
			end
			if (wr_compare_lo & sel_b) begin
				compare_value_b <= {temp_byte, avs_writedata};
			end
			if (wr_ce & (avs_address == `FCC_ADR_IRQ_ENABLE)) begin
				irq_enable_reg <= avs_writedata[7:1];
			end
			if (wr_ce & (avs_address == `FCC_ADR_CONTROL)) begin
				timer_control_reg <= avs_writedata;
			end
			if (wr_ce & (avs_address == `FCC_ADR_OUT_CTRL)) begin
				compare_output_ctrl_reg <= avs_writedata[4:0];
			end
			if (wr_ce & (avs_address == `FCC_ADR_STATUS)) begin
				clear_on_match_a <= avs_writedata[0];
			end
			// A new event in the clearing cycle keeps its flag set.
			status_flags <= (status_flags & ~flag_clr) | flag_set; // [RULE22]
			if (rd_ce & (avs_address == `FCC_ADR_STATUS)) begin
				flags_seen <= status_flags;
			end else begin
				flags_seen <= flags_seen & ~flag_clr;
			end
		end
	end

	// ==========================================================================
	// Compare outputs and the shared request.
	// The matched level is kept even while the output is disabled, so enabling
	// the pin shows the level of the last match at once.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			match_out_a <= 1'b0;
			match_out_b <= 1'b0;
			compare_pin_a <= 1'b0;
			compare_pin_b <= 1'b0;
			irq <= 1'b0;
		end else if (low_power_mode) begin
			match_out_a <= 1'b0;
			match_out_b <= 1'b0;
			compare_pin_a <= 1'b0;
			compare_pin_b <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (match_a) begin
				match_out_a <= compare_output_ctrl_reg[`FCC_OUT_LVL_A];
			end
			if (match_b) begin
				match_out_b <= compare_output_ctrl_reg[`FCC_OUT_LVL_B];
			end
			compare_pin_a <= compare_output_ctrl_reg[`FCC_OUT_EN_A] & match_out_a;
			compare_pin_b <= compare_output_ctrl_reg[`FCC_OUT_EN_B] & match_out_b;
			irq <= |(status_flags & irq_enable_reg); // [RULE10] [RULE21]
		end
	end
endmodule

// ===== testbench/fcc_timer_monitor.sv
// Checker of bus handshake, low-power hold and interrupt timing at the timer's ports.
module fcc_timer_monitor (
	input wire sys_clk,
	input wire nrst,
	input wire low_power_mode,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [7:0] avs_writedata,
	input wire [7:0] avs_readdata,
	input wire avs_waitrequest,
	input wire capture_pin_a,
	input wire compare_pin_a,
	input wire compare_pin_b,
	input wire irq
);
	timeunit 1ns;
	timeprecision 100ps;
	// ======
	// Shadow of the enable and control bytes, so the edge checks know what is armed.
	reg [7:0] ie;
	reg [7:0] ctl;
	wire wr_done = avs_write && !avs_waitrequest;
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ie <= 8'h00;
			ctl <= 8'h00;
		end else if (low_power_mode) begin
			ie <= 8'h00;
			ctl <= 8'h00;
		end else if (wr_done && avs_address == 5'h00) begin
			ie <= avs_writedata;
		end else if (wr_done && avs_address == 5'h06) begin
			ctl <= avs_writedata;
		end
	end
	// ======
	// Properties.
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	sequence lp_held;
		low_power_mode [*3];
	endsequence
	sequence lp_read(logic [4:0] a);
		lp_held ##0 (avs_read && !avs_waitrequest && avs_address == a);
	endsequence
	wait_answer_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	wait_single_a: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	idle_wait_a: assert property (
		!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without a request");
	lpm_quiet_a: assert property (
		lp_held ##1 low_power_mode |-> !irq && !compare_pin_a && !compare_pin_b)
		else $error("outputs active in low-power mode");
	lpm_count_a: assert property (
		lp_read(5'h02) |-> avs_readdata == 8'h00)
		else $error("counter not held at zero in low-power mode");
	lpm_ctrl_a: assert property (
		lp_read(5'h07) |-> avs_readdata == 8'hE0)
		else $error("output control not at reset value in low-power mode");
	cap_rise_a: assert property (disable iff (!nrst || low_power_mode)
		ctl[7] && ie[7] && $rose(capture_pin_a) |-> ##[1:4] irq)
		else $error("enabled rising capture raised no request");
	cap_fall_a: assert property (disable iff (!nrst || low_power_mode)
		!ctl[7] && ie[7] && $fell(capture_pin_a) |-> ##[1:4] irq)
		else $error("enabled falling capture raised no request");
	irq_mask_a: assert property (
		wr_done && avs_address == 5'h00 && avs_writedata == 8'h00 |-> ##2 !irq)
		else $error("request stays up with every source disabled");
endmodule
bind fcc_timer fcc_timer_monitor u_fcc_timer_monitor (
	.sys_clk(sys_clk), .nrst(nrst), .low_power_mode(low_power_mode),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .capture_pin_a(capture_pin_a),
	.compare_pin_a(compare_pin_a), .compare_pin_b(compare_pin_b), .irq(irq)
);

// ===== testbench/fcc_pins_model.sv
// Far-side model that drives the capture pins and the external counter clock.
module fcc_pins_model (
	input wire sys_clk,
	output logic [3:0] pins,
	output logic ext_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		pins = 4'h0;
		ext_clk = 1'b0;
	end
	// Two clocks high and two low keep every pulse above the minimum width.
	task automatic pulse(input int n);
		repeat (n) begin
			ext_clk <= 1'b1;
			repeat (2) @(posedge sys_clk);
			ext_clk <= 1'b0;
			repeat (2) @(posedge sys_clk);
		end
	endtask
	task automatic drive(input logic [3:0] v);
		pins <= v;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule

// ===== testbench/fcc_timer_tb_top.sv
// Self-checking bench for the capture/compare timer.
module fcc_timer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic low_power_mode = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [7:0] avs_writedata = 8'h00;
	wire [7:0] avs_readdata;
	wire avs_waitrequest;
	wire [3:0] pins;
	wire ext_clk;
	wire compare_pin_a;
	wire compare_pin_b;
	wire irq;
	int failures = 0;
	int comparisons = 0;
	int cyc = 0;
	int t;
	int n;
	logic [7:0] q;
	logic [15:0] r, v1, v2;
	logic [3:0] pk;
	logic [2:0] rb;
	logic [4:0] ra [8] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h1F};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hE0, 8'h00, 8'h00};
	always #2.5 sys_clk = ~sys_clk;
	fcc_timer u_fcc_timer (
		.sys_clk(sys_clk), .nrst(nrst), .low_power_mode(low_power_mode),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .capture_pin_a(pins[3]),
		.capture_pin_b(pins[2]), .capture_pin_c(pins[1]), .capture_pin_d(pins[0]),
		.ext_clk_pin(ext_clk), .compare_pin_a(compare_pin_a),
		.compare_pin_b(compare_pin_b), .irq(irq)
	);
	fcc_pins_model u_fcc_pins_model (.sys_clk(sys_clk), .pins(pins), .ext_clk(ext_clk));
	// ======
	// Comparison, bus and report tasks.
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// The divider phase at the first read is unknown, so a rate allows one tick either way.
	task automatic near(input logic [15:0] got, input int exp, input string m);
		comparisons++;
		if ($isunknown(got) || int'(got) < exp - 1 || int'(got) > exp + 1) begin
			failures++;
			$display("mismatch at %0t: %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr16(input logic [4:0] a, input logic [15:0] v);
		bus(1'b1, a, v[15:8]);
		bus(1'b1, a + 5'h01, v[7:0]);
	endtask
	task automatic rd16(input logic [4:0] a);
		bus(1'b0, a, 8'h00);
		r[15:8] = q;
		bus(1'b0, a + 5'h01, 8'h00);
		r[7:0] = q;
	endtask
	task automatic lp_clear;
		low_power_mode <= 1'b1;
		repeat (3) @(posedge sys_clk);
		bus(1'b0, 5'h02, 8'h00);
		cmp(q, 16'h0000, "counter in low power");
		bus(1'b0, 5'h07, 8'h00);
		cmp(q, 16'h00E0, "out ctrl in low power");
		low_power_mode <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			$display("mismatch at %0t: timeout", $time);
			final_report;
		end
	end
	// ======
	// Main sequence.
	initial begin
		void'($urandom(5813));
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		bus(1'b1, 5'h1F, 8'hA5);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 8'h00);
			cmp(q, rv[i], "reset value");
		end
		$display("test reset values done");
		for (int c = 0; c < 3; c++) begin
			bus(1'b1, 5'h06, 8'(c));
			rd16(5'h02);
			v1 = r;
			t = cyc;
			repeat (160) @(posedge sys_clk);
			rd16(5'h02);
			near(r - v1, (cyc - t) >> (2 * c + 1), "count rate");
		end
		$display("test clock pick done");
		lp_clear;
		bus(1'b1, 5'h06, 8'h03);
		bus(1'b1, 5'h07, 8'h0A);
		v1 = (16'($urandom) & 16'h7FFF) | 16'h0100;
		n = $urandom_range(1, 8);
		wr16(5'h04, v1);
		wr16(5'h02, v1 - 16'(n) + 16'h0001);
		u_fcc_pins_model.pulse(n - 1);
		rd16(5'h02);
		cmp(r, v1, "external count");
		bus(1'b0, 5'h01, 8'h00);
		cmp(q, 16'h0000, "no match while equal");
		cmp(compare_pin_a, 1'b0, "pin before match");
		u_fcc_pins_model.pulse(1);
		bus(1'b0, 5'h01, 8'h00);
		cmp(q, 16'h0008, "match on leaving");
		cmp(compare_pin_a, 1'b1, "pin after match");
		wr16(5'h02, 16'hFFFF);
		bus(1'b1, 5'h00, 8'h02);
		u_fcc_pins_model.pulse(1);
		rd16(5'h02);
		cmp(r, 16'h0000, "wrapped count");
		bus(1'b0, 5'h01, 8'h00);
		cmp(q, 16'h000E, "wrap and match flags");
		cmp(irq, 1'b1, "wrap request");
		bus(1'b1, 5'h00, 8'h00);
		@(posedge sys_clk);
		cmp(irq, 1'b0, "masked request");
		bus(1'b1, 5'h00, 8'h02);
		@(posedge sys_clk);
		cmp(irq, 1'b1, "unmasked request");
		bus(1'b1, 5'h01, 8'h00);
		bus(1'b0, 5'h01, 8'h00);
		cmp(q, 16'h0000, "flags cleared");
		cmp(irq, 1'b0, "request after clear");
		$display("test compare and wrap done");
		bus(1'b1, 5'h07, 8'h15);
		n = $urandom_range(1, 6);
		wr16(5'h04, 16'(n));
		rd16(5'h04);
		cmp(r, 16'(n), "compare b readback");
		u_fcc_pins_model.pulse(n + 1);
		bus(1'b0, 5'h01, 8'h00);
		cmp(q, 16'h0004, "match b flag");
		cmp(compare_pin_b, 1'b1, "pin b after match");
		bus(1'b1, 5'h01, 8'h01);
		bus(1'b1, 5'h07, 8'h05);
		wr16(5'h04, 16'(n + 3));
		u_fcc_pins_model.pulse(3);
		rd16(5'h02);
		cmp(r, 16'h0000, "cleared by match a");
		bus(1'b0, 5'h01, 8'h00);
		cmp(q, 16'h0009, "match a with clear");
		$display("test compare b and clear done");
		for (int k = 0; k < 2; k++) begin
			lp_clear;
			pk = (k == 0) ? 4'($urandom) : ~pk;
			bus(1'b1, 5'h06, {pk, 4'h3});
			bus(1'b1, 5'h00, 8'hF0);
			v1 = 16'($urandom);
			wr16(5'h02, v1);
			u_fcc_pins_model.drive(4'hF);
			bus(1'b0, 5'h01, 8'h00);
			cmp(q, {pk, 4'h0}, "rising edge flags");
			v2 = 16'($urandom);
			wr16(5'h02, v2);
			u_fcc_pins_model.drive(4'h0);
			bus(1'b0, 5'h01, 8'h00);
			cmp(q, 16'h00F0, "all capture flags");
			for (int i = 0; i < 4; i++) begin
				rd16(5'h08 + 5'(2 * i));
				cmp(r, pk[3 - i] ? v1 : v2, "capture value");
			end
		end
		$display("test capture done");
		lp_clear;
		bus(1'b1, 5'h06, 8'h8B);
		v1 = 16'($urandom);
		wr16(5'h02, v1);
		rb = 3'($urandom);
		u_fcc_pins_model.drive({1'b1, rb});
		v2 = 16'($urandom);
		wr16(5'h02, v2);
		u_fcc_pins_model.drive(4'h0);
		bus(1'b0, 5'h01, 8'h00);
		cmp(q, {1'b1, rb[2], 1'b1, rb[0], 4'h0}, "buffered flags");
		rd16(5'h08);
		cmp(r, v2, "main capture");
		rd16(5'h0C);
		cmp(r, v1, "buffer capture");
		rd16(5'h0A);
		cmp(r, rb[2] ? v2 : 16'h0000, "capture b beside buffer");
		rd16(5'h0E);
		cmp(r, rb[0] ? v2 : 16'h0000, "capture d unbuffered");
		$display("test buffered capture done");
		final_report;
	end
endmodule
